// ==== rtl/cfdd_consts.svh ====
// Named constants for the CAN-FD diagnostic and acceptance filter block
`ifndef CFDD_CONSTS_SVH
`define CFDD_CONSTS_SVH

// Register byte offsets
`define CFDD_OFF_DIAG      8'h00
`define CFDD_OFF_CTRL      8'h04
`define CFDD_OFF_FLTCON    8'h10
`define CFDD_OFF_FLTOBJ    8'h40
`define CFDD_OFF_MASK      8'h80
`define CFDD_OFF_END       8'hC0

// Diagnostic register fields
`define CFDD_B_LEN_MM      31
`define CFDD_B_ESI         30
`define CFDD_B_D_CRC       29
`define CFDD_B_D_STUFF     28
`define CFDD_B_D_FORM      27
`define CFDD_B_D_REC       25
`define CFDD_B_D_DOM       24
`define CFDD_B_BUS_OFF     23
`define CFDD_B_N_CRC       21
`define CFDD_B_N_STUFF     20
`define CFDD_B_N_FORM      19
`define CFDD_B_N_ACK       18
`define CFDD_B_N_REC       17
`define CFDD_B_N_DOM       16
`define CFDD_DATA_SHIFT    8
`define CFDD_FLAG_MASK     16'hFBBF
`define CFDD_CNT_W         16

// Filter control fields, one byte per filter
`define CFDD_FC_EN_BIT     7
`define CFDD_FC_PTR_W      5
`define CFDD_PER_CON       4
`define CFDD_NUM_FLT       16

// Pattern and mask fields
`define CFDD_OBJ_W         31
`define CFDD_OBJ_TYPE_BIT  30
`define CFDD_STANDARD_ID_EXTRA_BIT_BIT     29
`define CFDD_EID_LSB       11
`define CFDD_EID_MASK      30'h3FFFF800

// Protocol figures
`define CFDD_STUFF_LIMIT   3'h6
`define CFDD_RECOV_RUN     4'hB
`define CFDD_CRC_W         21
`define CFDD_CLASSIC_MAX   7'h08

// Reset values
`define CFDD_RST_WORD      32'h00000000

`endif

// ==== rtl/cfdd_pkg.sv ====
// Types for the CAN-FD diagnostic and acceptance filter block
`include "cfdd_consts.svh"

package cfdd_pkg;

  typedef struct packed {
    logic [15:0]                                  flags;
    logic [`CFDD_CNT_W-1:0]                       clean_message_count;
    logic                                         byte_filter_mode;
    logic [`CFDD_NUM_FLT-1:0]                     filter_enable;
    logic [`CFDD_NUM_FLT-1:0][`CFDD_FC_PTR_W-1:0] filter_object_pointer;
    logic [`CFDD_NUM_FLT-1:0][`CFDD_OBJ_W-1:0]    pattern;
    logic [`CFDD_NUM_FLT-1:0][`CFDD_OBJ_W-1:0]    mask;
    logic [2:0]                                   equal_run;
    logic                                         last_bit;
    logic [3:0]                                   recessive_run;
    logic                                         pready;
    logic                                         pslverr;
    logic [31:0]                                  prdata;
    logic                                         filter_hit;
    logic [`CFDD_FC_PTR_W-1:0]                    filter_hit_object;
    logic [3:0]                                   filter_hit_index;
  } cfdd_state_t;

endpackage

// ==== rtl/cfdd_diag_filter.sv ====
// CAN-FD error diagnostic flags, clean-message counter and acceptance filters
`include "cfdd_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module cfdd_diag_filter (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      bit_tick,
  input  wire logic                      rx_bit,
  input  wire logic                      tx_bit,
  input  wire logic                      transmitting,
  input  wire logic                      in_arbitration,
  input  wire logic                      stuff_region,
  input  wire logic                      data_phase,
  input  wire logic                      bus_off_recovery,
  input  wire logic                      form_check,
  input  wire logic                      ack_slot,
  input  wire logic                      crc_check,
  input  wire logic [`CFDD_CRC_W-1:0]    crc_received,
  input  wire logic [`CFDD_CRC_W-1:0]    crc_computed,
  input  wire logic                      esi_check,
  input  wire logic                      rx_esi,
  input  wire logic                      bus_off_recovered,
  input  wire logic                      frame_ok,
  input  wire logic                      dlc_check,
  input  wire logic [3:0]                frame_dlc,
  input  wire logic [2:0]                fifo_payload_size,
  input  wire logic                      rx_id_valid,
  input  wire logic                      rx_ide,
  input  wire logic [10:0]               rx_sid,
  input  wire logic                      rx_standard_id_extra_bit,
  input  wire logic [17:0]               rx_eid,
  input  wire logic [15:0]               rx_data01,
  output logic                           filter_hit,
  output logic [`CFDD_FC_PTR_W-1:0]      filter_hit_object,
  output logic [3:0]                     filter_hit_index
);

  cfdd_pkg::cfdd_state_t state;
  cfdd_pkg::cfdd_state_t next_state;

  // Length code to payload bytes
  function automatic logic [6:0] dlc_bytes(input logic [3:0] dlc);
    logic [6:0] b;
    b = 7'h00;
    unique case (dlc)
      4'h9:    b = 7'h0C;
      4'hA:    b = 7'h10;
      4'hB:    b = 7'h14;
      4'hC:    b = 7'h18;
      4'hD:    b = 7'h20;
      4'hE:    b = 7'h30;
      4'hF:    b = 7'h40;
      default: b = {3'h0, dlc};
    endcase
    return b;
  endfunction

  // FIFO payload size code to bytes
  function automatic logic [6:0] size_bytes(input logic [2:0] code);
    logic [6:0] b;
    b = `CFDD_CLASSIC_MAX;
    unique case (code)
      3'h0: b = `CFDD_CLASSIC_MAX;
      3'h1: b = 7'h0C;
      3'h2: b = 7'h10;
      3'h3: b = 7'h14;
      3'h4: b = 7'h18;
      3'h5: b = 7'h20;
      3'h6: b = 7'h30;
      3'h7: b = 7'h40;
    endcase
    return b;
  endfunction

  // Nominal flag position, moved to the data group at data rate
  function automatic logic [3:0] phase_bit(input logic [3:0] nominal_pos, input logic dp);
    logic [3:0] p;
    p = dp ? 4'(nominal_pos + 4'(`CFDD_DATA_SHIFT)) : nominal_pos;
    return p;
  endfunction

  // Compare one filter against the received frame
  function automatic logic filter_match(input logic [`CFDD_OBJ_W-1:0] pat,
                                        input logic [`CFDD_OBJ_W-1:0] msk,
                                        input logic [29:0]             rx_vec,
                                        input logic                    ide,
                                        input logic                    bytes_mode);
    logic [29:0] eff;
    logic        type_ok;
    eff = msk[29:0];
    // Standard frames carry no extended bits unless data bytes stand in for them
    if (!ide && !bytes_mode)
    begin
      eff = eff & ~`CFDD_EID_MASK;
    end
    type_ok = !msk[`CFDD_OBJ_TYPE_BIT] || (pat[`CFDD_OBJ_TYPE_BIT] == ide);
    return type_ok && (((rx_vec ^ pat[29:0]) & eff) == 30'h00000000);
  endfunction

  logic        apb_write;
  logic        apb_read;
  logic [7:0]  word_addr;
  logic [3:0]  reg_idx;
  logic [3:0]  con_idx;
  logic [29:0] rx_vector;
  logic [15:0] flag_set;
  logic [31:0] read_word;
  logic        read_ok;
  logic [2:0]  run_next;
  logic [3:0]  rec_next;
  logic [3:0]  dom_pos;
  logic [3:0]  pick;
  logic        any_hit;

  assign apb_write = psel && penable && state.pready && pwrite;
  assign apb_read  = psel && penable && !state.pready && !pwrite;
  assign word_addr = {paddr[7:2], 2'b00};
  assign reg_idx   = paddr[5:2];
  // Control words count from their own base, not from offset zero
  assign con_idx   = 4'(reg_idx - 4'(`CFDD_OFF_FLTCON >> 2));

  // Extended bits come from the first two data bytes in byte-filter mode
  assign rx_vector = {rx_standard_id_extra_bit,
                      state.byte_filter_mode ? {rx_data01, 2'b00} : rx_eid,
                      rx_sid};

  always_comb
  begin
    next_state = state;
    flag_set   = 16'h0000;
    read_word  = `CFDD_RST_WORD;
    read_ok    = 1'b1;
    run_next   = state.equal_run;
    rec_next   = state.recessive_run;
    dom_pos    = phase_bit(4'(`CFDD_B_N_DOM - 16), data_phase);
    pick       = 4'h0;
    any_hit    = 1'b0;

    // Protocol events
    if (dlc_check && (dlc_bytes(frame_dlc) > size_bytes(fifo_payload_size)))
    begin
      flag_set[`CFDD_B_LEN_MM - 16] = 1'b1;
    end
    if (esi_check && rx_esi)
    begin
      flag_set[`CFDD_B_ESI - 16] = 1'b1;
    end
    if (crc_check && (crc_received != crc_computed))
    begin
      flag_set[phase_bit(4'(`CFDD_B_N_CRC - 16), data_phase)] = 1'b1;
    end
    // Fixed-format fields (delimiters, end of frame) are all recessive
    if (form_check && bit_tick && !rx_bit)
    begin
      flag_set[phase_bit(4'(`CFDD_B_N_FORM - 16), data_phase)] = 1'b1;
    end
    // Acknowledge is always sent at nominal rate
    if (ack_slot && bit_tick && transmitting && rx_bit)
    begin
      flag_set[`CFDD_B_N_ACK - 16] = 1'b1;
    end
    if (bit_tick && transmitting && !in_arbitration && tx_bit && !rx_bit)
    begin
      flag_set[phase_bit(4'(`CFDD_B_N_REC - 16), data_phase)] = 1'b1;
    end
    // Ack slot and error flags reach here as dominant transmitted bits
    if (bit_tick && transmitting && !tx_bit && rx_bit)
    begin
      flag_set[dom_pos] = 1'b1;
    end
    if (bus_off_recovered)
    begin
      flag_set[`CFDD_B_BUS_OFF - 16] = 1'b1;
    end

    // Equal-bit run inside stuffed regions
    if (!stuff_region)
    begin
      run_next = 3'h0;
    end
    else if (bit_tick)
    begin
      if (state.equal_run != 3'h0 && rx_bit == state.last_bit)
      begin
        run_next = (state.equal_run == `CFDD_STUFF_LIMIT) ? state.equal_run
                                                          : 3'(state.equal_run + 3'h1);
      end
      else
      begin
        run_next = 3'h1;
      end
      if (run_next == `CFDD_STUFF_LIMIT && state.equal_run != `CFDD_STUFF_LIMIT)
      begin
        flag_set[phase_bit(4'(`CFDD_B_N_STUFF - 16), data_phase)] = 1'b1;
      end
    end
    next_state.equal_run = run_next;
    if (bit_tick)
    begin
      next_state.last_bit = rx_bit;
    end

    // Recessive runs during bus-off recovery, counted at nominal rate
    if (!bus_off_recovery)
    begin
      rec_next = 4'h0;
    end
    else if (bit_tick)
    begin
      rec_next = rx_bit ? 4'(state.recessive_run + 4'h1) : 4'h0;
      if (rec_next == `CFDD_RECOV_RUN)
      begin
        flag_set[`CFDD_B_N_DOM - 16] = 1'b1;
        rec_next = 4'h0;
      end
    end
    next_state.recessive_run = rec_next;

    // Software clears a flag by writing 0; a new event in the same cycle wins
    if (apb_write && word_addr == `CFDD_OFF_DIAG)
    begin
      next_state.flags = ((state.flags & pwdata[31:16]) | flag_set) & `CFDD_FLAG_MASK;
    end
    else
    begin
      next_state.flags = (state.flags | flag_set) & `CFDD_FLAG_MASK;
    end

    // Counter write loads, a message finishing in that cycle still counts
    if (apb_write && word_addr == `CFDD_OFF_DIAG)
    begin
      next_state.clean_message_count = pwdata[`CFDD_CNT_W-1:0];
    end
    if (frame_ok)
    begin
      next_state.clean_message_count = `CFDD_CNT_W'(next_state.clean_message_count + 16'h0001);
    end

    // Register writes
    if (apb_write && word_addr == `CFDD_OFF_CTRL)
    begin
      next_state.byte_filter_mode = pwdata[0];
    end
    if (apb_write && word_addr >= `CFDD_OFF_FLTCON && word_addr < `CFDD_OFF_FLTOBJ
        && con_idx < 4'(`CFDD_NUM_FLT / `CFDD_PER_CON))
    begin
      for (int k = 0; k < `CFDD_PER_CON; k++)
      begin
        // Pointer is locked while the filter runs; enable is always writable
        if (!state.filter_enable[con_idx * `CFDD_PER_CON + k])
        begin
          next_state.filter_object_pointer[con_idx * `CFDD_PER_CON + k] =
            pwdata[k*8 +: `CFDD_FC_PTR_W];
        end
        next_state.filter_enable[con_idx * `CFDD_PER_CON + k] =
          pwdata[k*8 + `CFDD_FC_EN_BIT];
      end
    end
    if (apb_write && word_addr >= `CFDD_OFF_FLTOBJ && word_addr < `CFDD_OFF_MASK
        && !state.filter_enable[reg_idx])
    begin
      next_state.pattern[reg_idx] = pwdata[`CFDD_OBJ_W-1:0];
    end
    if (apb_write && word_addr >= `CFDD_OFF_MASK && word_addr < `CFDD_OFF_END
        && !state.filter_enable[reg_idx])
    begin
      next_state.mask[reg_idx] = pwdata[`CFDD_OBJ_W-1:0];
    end

    // Read mux
    if (word_addr == `CFDD_OFF_DIAG)
    begin
      read_word = {state.flags, state.clean_message_count};
    end
    else if (word_addr == `CFDD_OFF_CTRL)
    begin
      read_word = {31'h00000000, state.byte_filter_mode};
    end
    else if (word_addr >= `CFDD_OFF_FLTCON && word_addr < `CFDD_OFF_FLTOBJ
             && con_idx < 4'(`CFDD_NUM_FLT / `CFDD_PER_CON))
    begin
      for (int k = 0; k < `CFDD_PER_CON; k++)
      begin
        read_word[k*8 + `CFDD_FC_EN_BIT] = state.filter_enable[con_idx * `CFDD_PER_CON + k];
        read_word[k*8 +: `CFDD_FC_PTR_W] =
          state.filter_object_pointer[con_idx * `CFDD_PER_CON + k];
      end
    end
    else if (word_addr >= `CFDD_OFF_FLTOBJ && word_addr < `CFDD_OFF_MASK)
    begin
      read_word = {1'b0, state.pattern[reg_idx]};
    end
    else if (word_addr >= `CFDD_OFF_MASK && word_addr < `CFDD_OFF_END)
    begin
      read_word = {1'b0, state.mask[reg_idx]};
    end
    else
    begin
      read_ok = 1'b0;
    end

    // One wait state keeps address decode off the answer path
    next_state.pready  = psel && penable && !state.pready;
    next_state.pslverr = psel && penable && !state.pready && !read_ok;
    if (apb_read)
    begin
      next_state.prdata = read_word;
    end

    // Acceptance: lowest numbered enabled filter wins
    for (int f = `CFDD_NUM_FLT - 1; f >= 0; f--)
    begin
      if (state.filter_enable[f]
          && filter_match(state.pattern[f], state.mask[f], rx_vector, rx_ide,
                          state.byte_filter_mode))
      begin
        any_hit = 1'b1;
        pick    = 4'(f);
      end
    end
    next_state.filter_hit        = rx_id_valid && any_hit;
    next_state.filter_hit_index  = pick;
    next_state.filter_hit_object = state.filter_object_pointer[pick];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign prdata            = state.prdata;
  assign pready            = state.pready;
  assign pslverr           = state.pslverr;
  assign filter_hit        = state.filter_hit;
  assign filter_hit_object = state.filter_hit_object;
  assign filter_hit_index  = state.filter_hit_index;

endmodule

`default_nettype wire

// ==== tb/cfdd_can_node.sv ====
// Far-side bus model: bit timing and wired-AND bus level
`timescale 1ns/1ps
`default_nettype none

module cfdd_can_node (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic tx_bit,
  input  wire logic node_dom,
  input  wire logic glitch,
  output logic      bit_tick,
  output logic      rx_bit
);
  logic [1:0] phase;

  // Four clocks a bit keeps recovery runs short
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      phase <= 2'h0;
    else
      phase <= phase + 2'h1;

  assign bit_tick = (phase == 2'h3);
  // Dominant wins on the wire; glitch stands for a disturbed line
  assign rx_bit = glitch ? ~tx_bit : (tx_bit & ~node_dom);
endmodule

`default_nettype wire

// ==== tb/cfdd_diag_filter_assertions.sv ====
// Checker for the register port, diagnostic flags and filter hit timing
`include "cfdd_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module cfdd_diag_filter_checker (
  input wire logic                   pclk,
  input wire logic                   presetn,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [7:0]             paddr,
  input wire logic [31:0]            pwdata,
  input wire logic [31:0]            prdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  input wire logic                   crc_check,
  input wire logic [`CFDD_CRC_W-1:0] crc_received,
  input wire logic [`CFDD_CRC_W-1:0] crc_computed,
  input wire logic                   data_phase,
  input wire logic                   bus_off_recovered,
  input wire logic                   rx_id_valid,
  input wire logic                   filter_hit
);
  logic [2:0] seen;
  logic [2:0] next_seen;
  logic       wr_diag;
  logic       rd_diag;
  logic       bad_crc;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  assign wr_diag = psel && penable && pready && pwrite && paddr == 8'h00;
  assign rd_diag = psel && penable && pready && !pwrite && paddr == 8'h00;
  assign bad_crc = crc_check && crc_received != crc_computed;

  // Shadow of three sticky flags; set wins over a clearing write
  always_comb
  begin
    next_seen = seen;
    if (wr_diag)
      next_seen = seen & {pwdata[23], pwdata[29], pwdata[21]};
    if (bad_crc && !data_phase)
      next_seen[0] = 1'b1;
    if (bad_crc && data_phase)
      next_seen[1] = 1'b1;
    if (bus_off_recovered)
      next_seen[2] = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      seen <= 3'h0;
    else
      seen <= next_seen;

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence

  a_ready_wait: assert property (s_setup ##1 s_access |-> !pready ##1 pready)
    else $error("pready not after one wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_unmapped: assert property (pready && psel && paddr >= 8'hC0 |-> pslverr)
    else $error("unmapped access not refused");
  a_err_shape: assert property (pslverr |-> pready && (pwrite || prdata == 32'h0))
    else $error("error response malformed");
  a_hit_cause: assert property (filter_hit |-> $past(rx_id_valid))
    else $error("filter hit without identifier");
  a_crc_nominal: assert property (rd_diag |-> prdata[21] == $past(seen[0]))
    else $error("nominal crc flag wrong");
  a_crc_data: assert property (rd_diag |-> prdata[29] == $past(seen[1]))
    else $error("data crc flag wrong");
  a_busoff_flag: assert property (rd_diag |-> prdata[23] == $past(seen[2]))
    else $error("bus-off flag wrong");
  a_diag_reserved: assert property (rd_diag |-> !prdata[26] && !prdata[22])
    else $error("reserved diag bit set");
  a_read_hold: assert property (!$stable(prdata) |-> pready && !pwrite)
    else $error("read data moved outside a read");
endmodule

bind cfdd_diag_filter cfdd_diag_filter_checker u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .crc_check(crc_check), .crc_received(crc_received), .crc_computed(crc_computed),
  .data_phase(data_phase), .bus_off_recovered(bus_off_recovered),
  .rx_id_valid(rx_id_valid), .filter_hit(filter_hit));

`default_nettype wire

// ==== tb/cfdd_diag_filter_tb.sv ====
// Self-checking bench for diagnostic flags, clean counter and filters
`include "cfdd_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module cfdd_diag_filter_tb;
  logic                   pclk, presetn, psel, penable, pwrite, perr, tx_bit, node_dom;
  logic                   glitch, bit_tick, rx_bit, pready, pslverr, filter_hit, transmitting;
  logic                   in_arbitration, stuff_region, data_phase, bus_off_recovery;
  logic                   form_check, ack_slot, crc_check, esi_check, rx_esi, frame_ok;
  logic                   bus_off_recovered, dlc_check, rx_id_valid, rx_ide, rx_standard_id_extra_bit;
  logic [7:0]             paddr;
  logic [31:0]            pwdata, prdata, rd, seed, cyc;
  logic [`CFDD_CRC_W-1:0] crc_received, crc_computed;
  logic [3:0]             frame_dlc, filter_hit_index;
  logic [2:0]             fifo_payload_size;
  logic [10:0]            rx_sid;
  logic [17:0]            rx_eid;
  logic [15:0]            rx_data01;
  logic [4:0]             filter_hit_object;
  logic [7:0]             rst_addr [4] = '{8'h00, 8'h10, 8'h40, 8'h80};
  int                     err_total, compares;

  cfdd_diag_filter u_cfdd_diag_filter (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .bit_tick, .rx_bit, .tx_bit, .transmitting,
    .in_arbitration, .stuff_region, .data_phase, .bus_off_recovery, .form_check, .ack_slot,
    .crc_check, .crc_received, .crc_computed, .esi_check, .rx_esi, .bus_off_recovered,
    .frame_ok, .dlc_check, .frame_dlc, .fifo_payload_size, .rx_id_valid, .rx_ide, .rx_sid,
    .rx_standard_id_extra_bit, .rx_eid, .rx_data01, .filter_hit, .filter_hit_object, .filter_hit_index);
  cfdd_can_node u_cfdd_can_node (.pclk, .presetn, .tx_bit, .node_dom, .glitch, .bit_tick,
    .rx_bit);

  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  function logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  // Flag position per event kind, data group eight above nominal
  function logic [15:0] want(input int k, input logic dp);
    logic [43:0] tab;
    logic [3:0]  p;
    tab = 44'h0F7E0012345;
    p = tab[4*k +: 4];
    if (k < 6 && k != 3 && dp)
      p = p + 4'h8;
    want = (k == 10) ? 16'h0 : 16'h1 << p;
  endfunction

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  task wrap_up();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task ev(input int k, input logic dp);
    logic [31:0] r;
    r = rnd();
    @(posedge pclk);
    data_phase <= dp;
    case (k)
      0: begin crc_check <= 1'b1; crc_received <= r[20:0]; crc_computed <= r[20:0] ^ 21'h1; end
      1: begin stuff_region <= 1'b1; node_dom <= 1'b1; end
      2: begin form_check <= 1'b1; node_dom <= 1'b1; end
      3: begin ack_slot <= 1'b1; transmitting <= 1'b1; end
      4: begin transmitting <= 1'b1; node_dom <= 1'b1; end
      5: begin transmitting <= 1'b1; tx_bit <= 1'b0; glitch <= 1'b1; end
      6: bus_off_recovery <= 1'b1;
      7: begin esi_check <= 1'b1; rx_esi <= 1'b1; end
      8: bus_off_recovered <= 1'b1;
      default: begin dlc_check <= 1'b1; frame_dlc <= (k == 9) ? 4'hF : 4'h8; end
    endcase
    fifo_payload_size <= r[31:29] % 3'h7;
    @(posedge pclk);
    {crc_check, esi_check, bus_off_recovered, dlc_check} <= 4'h0;
    // Over twelve bit times: covers six-bit and eleven-bit runs
    repeat (50) @(posedge pclk);
    {stuff_region, form_check, ack_slot, transmitting, node_dom, glitch} <= 6'h0;
    {bus_off_recovery, rx_esi, tx_bit} <= 3'h1;
    repeat (2) @(posedge pclk);
  endtask

  task idq(input logic ide, input logic [10:0] standard_id_pattern, input logic hit, input logic [3:0] f,
           input logic [4:0] p);
    logic [31:0] r;
    r = rnd();
    @(posedge pclk);
    {rx_id_valid, rx_ide, rx_sid, rx_eid, rx_data01} <= {1'b1, ide, standard_id_pattern, r[17:0], r[31:16]};
    @(posedge pclk);
    rx_id_valid <= 1'b0;
    @(posedge pclk);
    // Index and object only carry meaning alongside a hit
    chk({filter_hit, hit ? {filter_hit_index, filter_hit_object} : 9'h0}, {hit, hit ? {f, p} : 9'h0});
  endtask

  always @(posedge pclk)
  begin
    cyc <= cyc + 32'h1;
    if (cyc == 32'h4E20)
    begin
      err_total++;
      wrap_up();
    end
  end

  initial
  begin
    logic [31:0] r;
    logic [15:0] c;
    logic [7:0]  ca;
    logic [4:0]  sh, ptr;
    logic [3:0]  f;
    logic [10:0] standard_id_pattern;
    seed = 32'h45BBE50D;
    {presetn, psel, penable, pwrite, paddr, pwdata, transmitting, in_arbitration} = '0;
    {stuff_region, data_phase, bus_off_recovery, form_check, ack_slot, crc_check} = '0;
    {crc_received, crc_computed, esi_check, rx_esi, bus_off_recovered, frame_ok} = '0;
    {dlc_check, frame_dlc, fifo_payload_size, rx_id_valid, rx_ide, rx_sid, rx_standard_id_extra_bit} = '0;
    {rx_eid, rx_data01, node_dom, glitch, cyc, err_total, compares} = '0;
    tx_bit = 1'b1;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b0, rst_addr[i], 32'h0);
      chk(rd, 32'h0);
    end
    apb(1'b1, 8'hC4, rnd());
    apb(1'b0, 8'hC4, 32'h0);
    chk({rd[30:0], perr}, 32'h1);
    for (int k = 0; k < 11; k++)
      for (int dp = 0; dp < 2; dp++)
        if (dp == 0 || k < 6)
        begin
          apb(1'b1, 8'h00, 32'h0);
          ev(k, dp[0]);
          apb(1'b0, 8'h00, 32'h0);
          chk(rd, {want(k, dp[0]), 16'h0});
        end
    for (int i = 0; i < 2; i++)
    begin
      r = rnd();
      c = (i == 0) ? 16'hFFFE : r[15:0];
      apb(1'b1, 8'h00, {16'h0, c});
      frame_ok <= 1'b1;
      repeat (r[18:16] + 1) @(posedge pclk);
      frame_ok <= 1'b0;
      apb(1'b0, 8'h00, 32'h0);
      chk(rd[15:0], 16'(c + r[18:16] + 16'h1));
    end
    for (int i = 0; i < 3; i++)
    begin
      r = rnd();
      f = r[8:5];
      standard_id_pattern = r[19:9];
      ptr = (r[4:0] == 5'h0) ? 5'h1 : r[4:0];
      ca = 8'h10 + {4'h0, f[3:2], 2'h0};
      sh = {f[1:0], 3'h0};
      apb(1'b1, 8'h80 + {2'h0, f, 2'h0}, 32'h600007FF);
      apb(1'b1, 8'h40 + {2'h0, f, 2'h0}, {21'h0, standard_id_pattern});
      apb(1'b1, ca, {27'h0, ptr} << sh);
      apb(1'b1, ca, {24'h0, 3'h4, ptr} << sh);
      apb(1'b1, 8'h40 + {2'h0, f, 2'h0}, {21'h0, ~standard_id_pattern});
      apb(1'b1, ca, {24'h0, 3'h4, ptr[0], ptr[4:1]} << sh);
      apb(1'b0, 8'h40 + {2'h0, f, 2'h0}, 32'h0);
      chk(rd, {21'h0, standard_id_pattern});
      apb(1'b0, ca, 32'h0);
      chk(rd, {24'h0, 3'h4, ptr} << sh);
      idq(1'b0, standard_id_pattern, 1'b1, f, ptr);
      idq(1'b1, standard_id_pattern, 1'b0, f, ptr);
      idq(1'b0, standard_id_pattern ^ 11'h1, 1'b0, f, ptr);
      apb(1'b1, ca, {27'h0, ptr} << sh);
      idq(1'b0, standard_id_pattern, 1'b0, f, ptr);
    end
    // Byte-filter mode: data bytes sit where the extended bits would
    apb(1'b1, 8'h04, 32'h1);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h1);
    r = rnd();
    apb(1'b1, 8'h80, 32'h3FFFFFFF);
    apb(1'b1, 8'h40, {3'h0, r[15:0], 2'h0, r[26:16]});
    apb(1'b1, 8'h10, 32'h0000009F);
    for (int j = 0; j < 2; j++)
    begin
      @(posedge pclk);
      {rx_id_valid, rx_ide, rx_sid, rx_data01} <= {2'h3, r[26:16], r[15:0] ^ 16'(j)};
      @(posedge pclk);
      rx_id_valid <= 1'b0;
      @(posedge pclk);
      chk({filter_hit, (j == 0) ? {filter_hit_index, filter_hit_object} : 9'h000}, {j == 0, (j == 0) ? 9'h01F : 9'h000});
    end
    wrap_up();
  end
endmodule

`default_nettype wire
